// >>> hw/ntr_rights.sv
// Nested translation permission, snoop and memory type decision with APB control
`timescale 1ns/1ps

// Overview of operation
// - With nesting_enable set, accesses of a tagged request get second-level checks.
// - A fault is flagged at the first-level stage or any second-level stage.
// - Table pointer and entry fetches are checked as untagged requests.
// - Table reads need read permission in every controlling second-level entry.
// - Accessed/dirty flag updates need read and write permission.
// - The final page access is checked as a tagged request.
// - Final data reads need read permission.
// - With second_level_exec_enable clear, fetches need read permission.
// - With second_level_exec_enable set, fetches need read and execute permission.
// - Final page writes need write permission.
// - Final page atomics need read and write permission.
// - Permission inputs may come from translation caches, not fresh reads.
// - Root and context entry fetches snoop when the coherency bit is one.
// - Second-level entry fetches snoop when the coherency bit is one.
// - Address-space, first-level and final page accesses always snoop.
// - Memory type is applied only for coherent-domain requesters.
// - cache_disable set forces uncacheable_type on every access.
// - Root and context fetches always use uncacheable_type.
// - Second-level fetches use write_back_type, or context ext_mem_type when enabled.
// - Address-space fetches use range_register_type, or leaf ext_mem_type when enabled.
// - First-level and final accesses combine table type with range type.
// - With ext_mem_type_enable set, leaf ignore bit and ext_mem_type are used.
// - Ignore bit set selects leaf ext_mem_type outright.
// - Ignore bit clear combines table type with leaf ext_mem_type.
module ntr_rights #(
   parameter int CNT_W = 16
) (
   input  wire logic             pclk,     // 125 MHz clock
   input  wire logic             presetn,  // Async reset
   input  wire logic             psel,     // APB select
   input  wire logic             penable,  // APB enable
   input  wire logic             pwrite,   // APB direction
   input  wire logic [11:0]      paddr,    // APB byte address
   input  wire logic [31:0]      pwdata,   // APB write data
   output logic                  pready,   // APB ready
   output logic [31:0]           prdata,   // APB read data
   output logic                  pslverr,  // APB error
   input  wire ntr_pkg::ntr_req_s req_i,   // Access from walker
   output ntr_pkg::ntr_res_s     res_o     // Decision, one cycle later
);

   // Counters must fit their halves of the status word
   if (CNT_W < 1 || CNT_W > 16) begin : g_cnt_w_bad
      $error("CNT_W must be 1 to 16");
   end

   // Whole state of the block
   typedef struct packed {
      logic             nest;
      logic             second_level_exec_enable;
      logic             cd;
      logic             ext_mem_type_enable;
      logic             coh;
      logic [2:0]       ext_mem_type;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      logic [CNT_W-1:0] pcnt;
      logic [CNT_W-1:0] fcnt;
      ntr_pkg::ntr_res_s res;
   } ntr_state_s;

   ntr_state_s s_r;
   ntr_state_s s_nxt;

   // Address decode, used for the error response only
   function automatic logic reg_hit(input logic [11:0] a);
      reg_hit = (a == ntr_pkg::CTRL_OFS) || (a == ntr_pkg::STAT_OFS) ||
                (a == ntr_pkg::LAST_OFS);
   endfunction

   // Read value of a register, zero for unmapped
   function automatic logic [31:0] rd_val(input logic [11:0] a, input ntr_state_s s);
      logic [31:0] v;
      v = 32'h0;
      if (a == ntr_pkg::CTRL_OFS) begin
         v[ntr_pkg::NEST_BIT] = s.nest;
         v[ntr_pkg::SECOND_LEVEL_EXEC_ENABLE_BIT] = s.second_level_exec_enable;
         v[ntr_pkg::CD_BIT]   = s.cd;
         v[ntr_pkg::EXT_MEM_TYPE_ENABLE_BIT] = s.ext_mem_type_enable;
         v[ntr_pkg::COH_BIT]  = s.coh;
         v[ntr_pkg::EMT_LSB +: 3] = s.ext_mem_type;
      end else if (a == ntr_pkg::STAT_OFS) begin
         v[CNT_W-1:0] = s.pcnt;
         v[ntr_pkg::FCNT_LSB +: CNT_W] = s.fcnt;
      end else if (a == ntr_pkg::LAST_OFS) begin
         v[9:0] = s.res;
      end
      rd_val = v;
   endfunction

   // Decision terms for the incoming access
   logic       need_r;
   logic       need_w;
   logic       need_x;
   logic       sl_chk;
   logic       perm_ok;
   logic       bad_kind;
   logic       snoop;
   logic [2:0] mtype;

   // Permission needs per kind; cached permissions are as good as fresh ones
   always_comb begin
      need_r   = 1'b0;
      need_w   = 1'b0;
      need_x   = 1'b0;
      sl_chk   = 1'b1;
      bad_kind = 1'b0;
      unique case (req_i.kind)
         ntr_pkg::K_ROOTCTX: sl_chk = 1'b0;        // Not translated
         ntr_pkg::K_SLFETCH: sl_chk = 1'b0;        // Own rights checked by walker
         ntr_pkg::K_ASIDTAB,
         ntr_pkg::K_FLENTRY: need_r = 1'b1;
         ntr_pkg::K_FLADUPD: begin
            need_r = 1'b1;
            need_w = 1'b1;
         end
         ntr_pkg::K_DREAD:   need_r = 1'b1;
         ntr_pkg::K_IFETCH: begin
            need_r = 1'b1;
            need_x = s_r.second_level_exec_enable;
         end
         ntr_pkg::K_WRITE:   need_w = 1'b1;
         ntr_pkg::K_ATOMIC: begin
            need_r = 1'b1;
            need_w = 1'b1;
         end
         default: begin
            sl_chk   = 1'b0;
            bad_kind = 1'b1;
         end
      endcase
      // Without nesting the tagged accesses skip second-level checks
      if (!s_r.nest) begin
         sl_chk = 1'b0;
      end
      // Permission bits are taken as presented, possibly from caches
      perm_ok = (!need_r || req_i.sl_r) && (!need_w || req_i.sl_w) &&
                (!need_x || req_i.sl_x) && req_i.sl_valid;
   end

   // Snoop attribute and memory type per kind
   always_comb begin
      snoop = 1'b1;
      mtype = ntr_pkg::UNCACHEABLE_TYPE;
      unique case (req_i.kind)
         ntr_pkg::K_ROOTCTX: snoop = s_r.coh;
         ntr_pkg::K_SLFETCH: begin
            snoop = s_r.coh;
            mtype = s_r.ext_mem_type_enable ? s_r.ext_mem_type : ntr_pkg::WRITE_BACK_TYPE;
         end
         ntr_pkg::K_ASIDTAB:
            mtype = s_r.ext_mem_type_enable ? req_i.leaf_emt : req_i.range_register_type_type;
         ntr_pkg::K_FLENTRY, ntr_pkg::K_FLADUPD, ntr_pkg::K_DREAD,
         ntr_pkg::K_IFETCH, ntr_pkg::K_WRITE, ntr_pkg::K_ATOMIC: begin
            if (!s_r.ext_mem_type_enable) begin
               mtype = req_i.comb_range_register_type;
            end else if (req_i.leaf_ignore_attribute_bit) begin
               mtype = req_i.leaf_emt;
            end else begin
               mtype = req_i.comb_emt;
            end
         end
         default: mtype = ntr_pkg::UNCACHEABLE_TYPE;
      endcase
      // Cache disable overrides every computed type
      if (s_r.cd) begin
         mtype = ntr_pkg::UNCACHEABLE_TYPE;
      end
   end

   // Next state: APB slave, registers, counters and result
   always_comb begin
      logic acc;
      logic slf;
      acc = psel && penable;
      slf = sl_chk && !perm_ok;
      s_nxt = s_r;
      // One wait state so that pready comes from a flop
      if (acc && !s_r.pready) begin
         s_nxt.pready  = 1'b1;
         s_nxt.pslverr = !reg_hit(paddr);
         s_nxt.prdata  = pwrite ? 32'h0 : rd_val(paddr, s_r);
      end else begin
         s_nxt.pready  = 1'b0;
         s_nxt.pslverr = 1'b0;
         s_nxt.prdata  = 32'h0;
      end
      // Writes land at the edge where pready is seen high
      if (acc && s_r.pready && pwrite) begin
         if (paddr == ntr_pkg::CTRL_OFS) begin
            s_nxt.nest = pwdata[ntr_pkg::NEST_BIT];
            s_nxt.second_level_exec_enable = pwdata[ntr_pkg::SECOND_LEVEL_EXEC_ENABLE_BIT];
            s_nxt.cd   = pwdata[ntr_pkg::CD_BIT];
            s_nxt.ext_mem_type_enable = pwdata[ntr_pkg::EXT_MEM_TYPE_ENABLE_BIT];
            s_nxt.coh  = pwdata[ntr_pkg::COH_BIT];
            s_nxt.ext_mem_type  = pwdata[ntr_pkg::EMT_LSB +: 3];
         end else if (paddr == ntr_pkg::STAT_OFS) begin
            s_nxt.pcnt = '0;
            s_nxt.fcnt = '0;
         end
      end
      // Decision; a fault is reported with the stage that raised it
      s_nxt.res.valid        = req_i.valid;
      s_nxt.res.fault        = req_i.valid && (req_i.fl_fault || slf || bad_kind);
      s_nxt.res.permit       = req_i.valid && !(req_i.fl_fault || slf || bad_kind);
      s_nxt.res.stage        = !req_i.valid ? ntr_pkg::STAGE_NONE :
                               req_i.fl_fault ? ntr_pkg::STAGE_FL :
                               (slf || bad_kind) ? ntr_pkg::STAGE_SL : ntr_pkg::STAGE_NONE;
      s_nxt.res.snoop        = req_i.valid && snoop;
      s_nxt.res.type_applies = req_i.valid && req_i.coherent;
      s_nxt.res.mem_type     = (req_i.valid && req_i.coherent) ? mtype :
                               ntr_pkg::UNCACHEABLE_TYPE;
      // Counting wins over a clear in the same cycle; saturating
      if (s_nxt.res.permit && (s_nxt.pcnt != '1)) begin
         s_nxt.pcnt = s_nxt.pcnt + 1'b1;
      end
      if (s_nxt.res.fault && (s_nxt.fcnt != '1)) begin
         s_nxt.fcnt = s_nxt.fcnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r      <= '0;
         s_r.ext_mem_type  <= ntr_pkg::EMT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state flops
   assign pready  = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign prdata  = s_r.prdata;
   assign res_o   = s_r.res;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Helper: final-page and table kinds that must snoop
   logic always_snp;
   assign always_snp = req_i.kind inside {ntr_pkg::K_ASIDTAB, ntr_pkg::K_FLENTRY,
                       ntr_pkg::K_FLADUPD, ntr_pkg::K_DREAD, ntr_pkg::K_IFETCH,
                       ntr_pkg::K_WRITE, ntr_pkg::K_ATOMIC};

   chk_tab_read_r: assert property (
      req_i.valid && s_r.nest && !req_i.fl_fault && req_i.kind == ntr_pkg::K_FLENTRY && !req_i.sl_r
      |=> res_o.fault && res_o.stage == ntr_pkg::STAGE_SL)
      else $error("table read permitted without read right");

   chk_adupd_rw: assert property (
      req_i.valid && s_r.nest && !req_i.fl_fault && req_i.kind == ntr_pkg::K_FLADUPD
      |=> res_o.permit == $past(req_i.sl_r && req_i.sl_w && req_i.sl_valid))
      else $error("flag update decision wrong");

   chk_dread_r: assert property (
      req_i.valid && s_r.nest && !req_i.fl_fault && req_i.kind == ntr_pkg::K_DREAD
      |=> res_o.permit == $past(req_i.sl_r && req_i.sl_valid))
      else $error("data read decision wrong");

   chk_ifetch_x: assert property (
      req_i.valid && s_r.nest && s_r.second_level_exec_enable && req_i.kind == ntr_pkg::K_IFETCH && !req_i.sl_x
      |=> !res_o.permit)
      else $error("fetch permitted without execute right");

   chk_write_w: assert property (
      req_i.valid && s_r.nest && !req_i.fl_fault && req_i.kind == ntr_pkg::K_WRITE
      |=> res_o.permit == $past(req_i.sl_w && req_i.sl_valid))
      else $error("write decision wrong");

   chk_atomic_rw: assert property (
      req_i.valid && s_r.nest && req_i.kind == ntr_pkg::K_ATOMIC && !(req_i.sl_r && req_i.sl_w)
      |=> !res_o.permit)
      else $error("atomic permitted without rights");

   chk_snoop_always: assert property (
      req_i.valid && always_snp |=> res_o.snoop)
      else $error("access not snooped");

   chk_root_snoop: assert property (
      req_i.valid && req_i.kind == ntr_pkg::K_ROOTCTX |=> res_o.snoop == $past(s_r.coh))
      else $error("root fetch snoop does not follow coherency bit");

   chk_cd_uncache: assert property (
      req_i.valid && s_r.cd |=> res_o.mem_type == ntr_pkg::UNCACHEABLE_TYPE)
      else $error("cache disable ignored");

   chk_apb_ready: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("pready not a single cycle after one wait");

   // Helper: first-level entry fetches, flag updates and final-page accesses
   logic fl_side;
   assign fl_side = always_snp && (req_i.kind != ntr_pkg::K_ASIDTAB);

   chk_nest_no_sl: assert property (
      req_i.valid && s_r.nest && always_snp && !req_i.sl_valid
      |=> res_o.fault)
      else $error("missing second-level translation not faulted");

   chk_nest_off_ok: assert property (
      req_i.valid && !s_r.nest && always_snp && !req_i.fl_fault
      |=> res_o.permit)
      else $error("second-level check made with nesting off");

   chk_fl_stage: assert property (
      req_i.valid && req_i.fl_fault
      |=> res_o.fault && res_o.stage == ntr_pkg::STAGE_FL)
      else $error("first-level fault not reported at first level");

   chk_ptr_fetch_r: assert property (
      req_i.valid && s_r.nest && !req_i.fl_fault && req_i.kind == ntr_pkg::K_ASIDTAB
      |=> res_o.permit == $past(req_i.sl_r && req_i.sl_valid))
      else $error("table pointer fetch decision wrong");

   chk_ifetch_r: assert property (
      req_i.valid && s_r.nest && !s_r.second_level_exec_enable && !req_i.fl_fault && req_i.kind == ntr_pkg::K_IFETCH
      |=> res_o.permit == $past(req_i.sl_r && req_i.sl_valid))
      else $error("fetch decision wrong with execute checks off");

   chk_sl_snoop: assert property (
      req_i.valid && req_i.kind == ntr_pkg::K_SLFETCH
      |=> res_o.snoop == $past(s_r.coh))
      else $error("entry fetch snoop does not follow coherency bit");

   chk_type_outside: assert property (
      req_i.valid && !req_i.coherent
      |=> !res_o.type_applies && res_o.mem_type == ntr_pkg::UNCACHEABLE_TYPE)
      else $error("memory type applied outside coherency domain");

   chk_root_uncache: assert property (
      req_i.valid && req_i.kind == ntr_pkg::K_ROOTCTX
      |=> res_o.mem_type == ntr_pkg::UNCACHEABLE_TYPE)
      else $error("root fetch not uncacheable");

   chk_sl_wb: assert property (
      req_i.valid && req_i.coherent && !s_r.cd && !s_r.ext_mem_type_enable && req_i.kind == ntr_pkg::K_SLFETCH
      |=> res_o.mem_type == ntr_pkg::WRITE_BACK_TYPE)
      else $error("entry fetch not write-back");

   chk_sl_emt: assert property (
      req_i.valid && req_i.coherent && !s_r.cd && s_r.ext_mem_type_enable && req_i.kind == ntr_pkg::K_SLFETCH
      |=> res_o.mem_type == $past(s_r.ext_mem_type))
      else $error("entry fetch ignores context type");

   chk_tab_range: assert property (
      req_i.valid && req_i.coherent && !s_r.cd && !s_r.ext_mem_type_enable && req_i.kind == ntr_pkg::K_ASIDTAB
      |=> res_o.mem_type == $past(req_i.range_register_type_type))
      else $error("table fetch ignores range type");

   chk_tab_leaf: assert property (
      req_i.valid && req_i.coherent && !s_r.cd && s_r.ext_mem_type_enable && req_i.kind == ntr_pkg::K_ASIDTAB
      |=> res_o.mem_type == $past(req_i.leaf_emt))
      else $error("table fetch ignores leaf type");

   chk_final_comb: assert property (
      req_i.valid && req_i.coherent && !s_r.cd && !s_r.ext_mem_type_enable && fl_side
      |=> res_o.mem_type == $past(req_i.comb_range_register_type))
      else $error("access ignores range combination");

   chk_ignore_attribute_bit_emt: assert property (
      req_i.valid && req_i.coherent && !s_r.cd && s_r.ext_mem_type_enable && fl_side && req_i.leaf_ignore_attribute_bit
      |=> res_o.mem_type == $past(req_i.leaf_emt))
      else $error("ignore bit set but leaf type not used");

   chk_ignore_attribute_bit_comb: assert property (
      req_i.valid && req_i.coherent && !s_r.cd && s_r.ext_mem_type_enable && fl_side && !req_i.leaf_ignore_attribute_bit
      |=> res_o.mem_type == $past(req_i.comb_emt))
      else $error("ignore bit clear but leaf combination not used");

   chk_res_idle: assert property (
      !req_i.valid
      |=> res_o == '0)
      else $error("decision shown without a request");

endmodule

// >>> hw/ntr_pkg.sv
// Package: types and constants for the nested translation rights and attributes block
package ntr_pkg;
   // Memory type encodings
   localparam logic [2:0] UNCACHEABLE_TYPE = 3'h0;
   localparam logic [2:0] WRITE_BACK_TYPE  = 3'h6;
   // Register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] LAST_OFS = 12'h008;
   // Control and status register field positions
   localparam int NEST_BIT  = 0;
   localparam int SECOND_LEVEL_EXEC_ENABLE_BIT  = 1;
   localparam int CD_BIT    = 2;
   localparam int EXT_MEM_TYPE_ENABLE_BIT  = 3;
   localparam int COH_BIT   = 4;
   localparam int EMT_LSB   = 8;
   localparam int FCNT_LSB  = 16;
   // Values after reset
   localparam logic [2:0] EMT_RST = 3'h6;
   // Fault stages
   localparam logic [1:0] STAGE_NONE = 2'h0;
   localparam logic [1:0] STAGE_FL   = 2'h1;
   localparam logic [1:0] STAGE_SL   = 2'h2;

   // Access kinds seen by the block
   typedef enum logic [3:0] {
      K_ROOTCTX = 4'h0,  // Extended root or context entry fetch
      K_SLFETCH = 4'h1,  // Second-level entry fetch
      K_ASIDTAB = 4'h2,  // Address-space-table entry fetch
      K_FLENTRY = 4'h3,  // First-level pointer or entry fetch
      K_FLADUPD = 4'h4,  // Atomic accessed/extended-accessed/dirty update
      K_DREAD   = 4'h5,  // Final page data read
      K_IFETCH  = 4'h6,  // Final page fetch, execute_requested set
      K_WRITE   = 4'h7,  // Final page write
      K_ATOMIC  = 4'h8   // Final page atomic
   } ntr_kind_e;

   // One access presented by the walker
   typedef struct packed {
      logic       valid;
      ntr_kind_e  kind;
      logic       sl_valid;     // Second-level translation exists
      logic       sl_r;         // AND of read bits of controlling entries
      logic       sl_w;         // AND of write bits
      logic       sl_x;         // AND of execute bits
      logic       fl_fault;     // First-level stage already failed
      logic       coherent;     // Requester in processor coherency domain
      logic       leaf_ignore_attribute_bit;    // ignore_attribute_bit of leaf entry
      logic [2:0] leaf_emt;     // ext_mem_type of leaf entry
      logic [2:0] range_register_type_type;    // range_register_type
      logic [2:0] comb_range_register_type;    // page_attribute_table type combined with range_register_type
      logic [2:0] comb_emt;     // page_attribute_table type combined with emt
   } ntr_req_s;

   // Decision for one access
   typedef struct packed {
      logic       valid;
      logic       permit;
      logic       fault;
      logic [1:0] stage;
      logic       snoop;
      logic       type_applies;
      logic [2:0] mem_type;
   } ntr_res_s;
endpackage

// >>> test/ntr_walker_model.sv
// Walker-side model that presents accesses to the decision block
`timescale 1ns/1ps
module ntr_walker_model (
   input  wire logic        pclk,    // Clock
   input  wire logic        presetn, // Async reset, active low
   input  wire logic        go,      // Present an access next cycle
   input  wire logic [3:0]  kind,    // Access kind, 9..15 illegal
   input  wire logic [31:0] w,       // Random field source
   output ntr_pkg::ntr_req_s req_o   // Access toward the block
);
   ntr_pkg::ntr_req_s nx;

   // Idle cycles still carry changing fields, so only valid may qualify them
   always_comb begin
      nx = ntr_pkg::ntr_req_s'(w[23:0]);
      nx.valid = go;
      nx.kind = ntr_pkg::ntr_kind_e'(kind);
      nx.sl_valid = |w[25:24];
      nx.fl_fault = (w[28:26] == 3'h0) && (kind < 4'h9);
      // A first-level fault comes with clean second-level rights, so the stage is unambiguous
      if (nx.fl_fault) begin
         {nx.sl_valid, nx.sl_r, nx.sl_w, nx.sl_x} = 4'hf;
      end
   end

   // Launch right after the edge, held for one whole cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_o <= '0;
      end else begin
         req_o <= nx;
      end
   end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the nested translation rights block
`timescale 1ns/1ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, mon_on, exp_v;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd, w, q;
   logic [3:0] kind;
   logic [10:0] ctrl_sh;
   logic e;
   ntr_pkg::ntr_req_s req;
   ntr_pkg::ntr_res_s res, exp_q;
   int fail_count, tests_run, n_ok, n_bad;

   ntr_rights #(.CNT_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .req_i(req), .res_o(res));
   ntr_walker_model wm (.pclk(pclk), .presetn(presetn), .go(go), .kind(kind), .w(w), .req_o(req));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Reference decision worked out from the access rules
   function automatic ntr_pkg::ntr_res_s exp_res(input ntr_pkg::ntr_req_s r, input logic [10:0] c);
      ntr_pkg::ntr_res_s x;
      logic bad, ok;
      int k;
      x = '0;
      k = int'(r.kind);
      if (!r.valid) return x;
      bad = k > 8;
      case (k)
         2, 3, 5: ok = r.sl_r;
         4, 8: ok = r.sl_r & r.sl_w;
         7: ok = r.sl_w;
         6: ok = r.sl_r & (r.sl_x | !c[ntr_pkg::SECOND_LEVEL_EXEC_ENABLE_BIT]);
         default: ok = 1'b1;
      endcase
      x.valid = 1'b1;
      x.fault = r.fl_fault | bad | (c[ntr_pkg::NEST_BIT] && k >= 2 && k <= 8 && !(ok & r.sl_valid));
      x.permit = !x.fault;
      x.stage = r.fl_fault ? ntr_pkg::STAGE_FL : (x.fault ? ntr_pkg::STAGE_SL : ntr_pkg::STAGE_NONE);
      x.snoop = (k < 2) ? c[ntr_pkg::COH_BIT] : 1'b1;
      x.type_applies = r.coherent;
      if (!r.coherent || c[ntr_pkg::CD_BIT] || bad || k == 0) x.mem_type = ntr_pkg::UNCACHEABLE_TYPE;
      else if (k == 1) x.mem_type = c[ntr_pkg::EXT_MEM_TYPE_ENABLE_BIT] ? c[10:8] : ntr_pkg::WRITE_BACK_TYPE;
      else if (k == 2) x.mem_type = c[ntr_pkg::EXT_MEM_TYPE_ENABLE_BIT] ? r.leaf_emt : r.range_register_type_type;
      else if (!c[ntr_pkg::EXT_MEM_TYPE_ENABLE_BIT]) x.mem_type = r.comb_range_register_type;
      else x.mem_type = r.leaf_ignore_attribute_bit ? r.leaf_emt : r.comb_emt;
      return x;
   endfunction

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
      tests_run++;
      if (sn !== ex) begin
         $display("wrong value %s expected %h seen %h", nm, ex, sn);
         fail_count++;
      end
   endtask

   task automatic report_and_stop();
      if (fail_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One APB transfer; request held until pready is seen at an edge, then one idle edge
   // so that the next setup never drives psel twice in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk("pready wait", 32'h2, 32'(n));
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Back-to-back accesses, every legal kind plus illegal kinds 9 and 10, a gap now and then
   task automatic burst(input int cnt);
      for (int i = 0; i < cnt; i++) begin
         rnd = lfsr_next(rnd);
         go <= (i % 7 != 6);
         kind <= 4'(i % 11);
         w <= rnd;
         @(posedge pclk);
      end
      go <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   // Result compared one cycle after each access, idle cycles must read all zero
   always @(posedge pclk) begin
      if (mon_on && exp_v) begin
         chk("res_o", {22'h0, exp_q}, {22'h0, res});
         n_ok = n_ok + int'(exp_q.valid & exp_q.permit);
         n_bad = n_bad + int'(exp_q.valid & exp_q.fault);
      end
      exp_q <= exp_res(req, ctrl_sh);
      exp_v <= mon_on;
   end

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Cuts a hang short well past the expected run length
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end

   initial begin
      {presetn, psel, penable, pwrite, go, mon_on, exp_v} = '0;
      {paddr, pwdata, kind, w, ctrl_sh} = '0;
      fail_count = 0;
      tests_run = 0;
      rnd = 32'h1443;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      mon_on <= 1'b1;
      apb(1'b0, ntr_pkg::CTRL_OFS, 32'h0);
      chk("ctrl reset", {21'h0, ntr_pkg::EMT_RST, 8'h0}, q);
      apb(1'b0, ntr_pkg::STAT_OFS, 32'h0);
      chk("stat reset", 32'h0, q);
      apb(1'b1, 12'h00c, 32'hffffffff);
      chk("unmapped write err", 32'h1, {31'h0, e});
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped read", 32'h1, {q[30:0], e});
      // Every combination of the five control bits with a random extended type
      for (int cfg = 0; cfg < 32; cfg++) begin
         rnd = lfsr_next(rnd);
         ctrl_sh = {rnd[2:0], 3'h0, 5'(cfg)};
         apb(1'b1, ntr_pkg::CTRL_OFS, {21'h0, ctrl_sh});
         apb(1'b0, ntr_pkg::CTRL_OFS, 32'h0);
         chk("ctrl", {21'h0, ctrl_sh}, q);
         chk("ctrl err", 32'h0, {31'h0, e});
         apb(1'b1, ntr_pkg::STAT_OFS, rnd);
         n_ok = 0;
         n_bad = 0;
         burst(33);
         apb(1'b0, ntr_pkg::STAT_OFS, 32'h0);
         chk("stat", {16'(n_bad), 16'(n_ok)}, q);
         apb(1'b0, ntr_pkg::LAST_OFS, 32'h0);
         chk("last idle", 32'h0, q);
      end
      report_and_stop();
   end
endmodule
